/* File: design/mbp_clk_watchdog.sv */
/*
 * reference clock watchdog: flags loss when no edge arrives within limit + 1
 * core cycles. assumes ref_edge is already synchronised, one cycle wide.
 */
module mbp_clk_watchdog (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // link to the supervisor
  mbp_wd_if.wd wd
);

  logic [15:0] gap_ff;
  logic lost_ff;

  // ***************************************************************
  // gap counter
  // ***************************************************************
  // edge-free cycle count
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_ff <= 16'h0000;
      lost_ff <= 1'b0;
    end else if (!wd.enable || wd.ref_edge) begin
      gap_ff <= 16'h0000;
      lost_ff <= 1'b0;
    end else if (gap_ff >= wd.limit) begin
      lost_ff <= 1'b1; // stays until an edge comes back or enable drops
    end else begin
      gap_ff <= gap_ff + 16'h0001;
    end
  end

  assign wd.lost = lost_ff;

endmodule // mbp_clk_watchdog

/* File: design/mbp_ctrl.sv */
/*
 * brake and protection supervisor for a three-phase pre-driver: gates the
 * six gate enables from power-on reset, undervoltage, rotor lock latch,
 * clock loss and brake, with an apb register slave.
 * assumes comparator and pin levels arrive asynchronously and the
 * commutation, pwm and over-current inputs come from core-clock logic.
 */

// What this block does
// - braking, unless power-on reset, undervoltage, the latch or clock loss wins, turns all high-side drives on and all low-side drives off
// - current limiting is ignored while braking
// - braking forces full on-duty whatever the speed
// - brake is applied and released while staying in the start state
// - stop saves power; a fresh start waits for oscillator settling
// - lock flag high for the timeout in start latches high-side off
// - the rotor lock timeout is a configurable count
// - stop held about 1 ms, or power cycle, clears the latch
// - power-on reset pin held low keeps all drive off
// - passive timer termination disables lock and clock-loss protection
// - clock loss in start state turns the pwm drive off
// - clock return before lock timeout resumes drive by itself
// - a latch tripped during clock loss clears by 1 ms stop or brake
// - undervoltage turns high side off; recovery needs the upper threshold
// - lock flag is low inside the speed window, high outside
module mbp_ctrl #(
  parameter int unsigned STOP_CLEAR_CYC = 32'(mbp_pkg::STOP_CLEAR_CYC),
  parameter int unsigned LOCK_TIMEOUT_CYC = 32'(mbp_pkg::LOCK_TIMEOUT_CYC),
  parameter int unsigned SETTLE_CYC = 32'(mbp_pkg::SETTLE_CYC)
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // asynchronous pins and comparators
  input wire logic ref_clk_pin_i,
  input wire logic speed_in_window_i,
  input wire logic protect_timer_reset_pin_i,
  input wire logic timer_pin_passive_i,
  input wire logic vcc_below_low_i,
  input wire logic vcc_above_high_i,
  // commutation and pwm from core-clock logic
  input wire logic [2:0] comm_high_i,
  input wire logic [2:0] comm_low_i,
  input wire logic pwm_on_i,
  input wire logic over_current_i,
  // gate enables
  output logic phase_a_high_drive_o,
  output logic phase_b_high_drive_o,
  output logic phase_c_high_drive_o,
  output logic [2:0] low_drive_o,
  // status toward the rest of the chip
  output logic speed_lock_flag_out_o,
  output logic duty_full_o,
  output logic current_limit_en_o,
  output logic power_save_o,
  output logic speed_ctrl_en_o
);

  initial begin
    if (STOP_CLEAR_CYC < 1 || SETTLE_CYC < 1 || LOCK_TIMEOUT_CYC < 1) begin
      $error("mbp_ctrl: cycle counts must be at least one");
    end
  end

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [5:0] meta_ff;
  logic [5:0] sync_ff;
  logic ref_prev_ff;

  // two stages before any logic looks at a pin
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      meta_ff <= 6'h00;
      sync_ff <= 6'h00;
      ref_prev_ff <= 1'b0;
    end else begin
      meta_ff <= {vcc_above_high_i, vcc_below_low_i, timer_pin_passive_i,
                  protect_timer_reset_pin_i, speed_in_window_i, ref_clk_pin_i};
      sync_ff <= meta_ff;
      ref_prev_ff <= sync_ff[0];
    end
  end

  logic ref_s, in_window_s, por_pin_s, passive_s, below_s, above_s;
  assign {above_s, below_s, passive_s, por_pin_s, in_window_s, ref_s} = sync_ff;

  // pin low means power-on reset held
  logic por_act;
  assign por_act = !por_pin_s;

  // ***************************************************************
  // registers
  // ***************************************************************
  logic stop_ff;
  logic brake_ff;
  logic [31:0] lock_tmo_ff;
  logic [15:0] clk_wd_ff;
  logic wr_en;
  logic access;

  assign access = psel_i && penable_i;
  assign wr_en = access && pwrite_i;

  // software writes; start state is stop bit low, brake works in it
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stop_ff <= mbp_pkg::CTRL_STOP_RST;
      brake_ff <= mbp_pkg::CTRL_BRAKE_RST;
      lock_tmo_ff <= LOCK_TIMEOUT_CYC;
      clk_wd_ff <= mbp_pkg::CLK_WD_RST;
    end else if (wr_en) begin
      unique case (paddr_i)
        mbp_pkg::CTRL_OFS: begin
          stop_ff <= pwdata_i[mbp_pkg::CTRL_STOP_BIT];
          brake_ff <= pwdata_i[mbp_pkg::CTRL_BRAKE_BIT];
        end
        mbp_pkg::LOCK_TMO_OFS: lock_tmo_ff <= pwdata_i;
        mbp_pkg::CLK_WD_OFS: clk_wd_ff <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ***************************************************************
  // run state and settle wait
  // ***************************************************************
  mbp_pkg::mbp_state_t state_ff;
  logic [31:0] settle_ff;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= mbp_pkg::MBP_STOPPED;
      settle_ff <= 32'h0000_0000;
    end else if (stop_ff || por_act) begin
      state_ff <= mbp_pkg::MBP_STOPPED;
      settle_ff <= 32'h0000_0000;
    end else begin
      unique case (state_ff)
        mbp_pkg::MBP_STOPPED: state_ff <= mbp_pkg::MBP_SETTLING;
        mbp_pkg::MBP_SETTLING: begin
          if (settle_ff >= SETTLE_CYC - 1) begin
            state_ff <= mbp_pkg::MBP_RUNNING;
          end else begin
            settle_ff <= settle_ff + 32'h0000_0001;
          end
        end
        mbp_pkg::MBP_RUNNING: ;
      endcase
    end
  end

  logic start_st;
  assign start_st = !stop_ff;

  // ***************************************************************
  // undervoltage with hysteresis
  // ***************************************************************
  logic uv_ff;

  // trip below low, clear only above high
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      uv_ff <= 1'b1; // assume low supply until proven
    end else if (below_s) begin
      uv_ff <= 1'b1;
    end else if (above_s) begin
      uv_ff <= 1'b0;
    end
  end

  // ***************************************************************
  // clock watchdog
  // ***************************************************************
  mbp_wd_if wd_bus ();
  logic clk_lost;

  // passive timer pin also disables clock-loss protection
  assign wd_bus.enable = start_st && !passive_s && !por_act;
  assign wd_bus.ref_edge = ref_s ^ ref_prev_ff;
  assign wd_bus.limit = clk_wd_ff;
  assign clk_lost = wd_bus.lost;

  mbp_clk_watchdog u_wd (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .wd(wd_bus)
  );

  // ***************************************************************
  // lock flag and rotor lock latch
  // ***************************************************************
  logic lock_flag_ff;
  logic [31:0] lock_cnt_ff;
  logic latch_ff;
  logic latch_clk_ff;
  logic [31:0] hold_cnt_ff;
  logic hold_cond;
  logic hold_done;
  logic latch_set;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_flag_ff <= 1'b1;
    end else begin
      lock_flag_ff <= !in_window_s;
    end
  end

  // continuous flag-high time in start state
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      lock_cnt_ff <= 32'h0000_0000;
    end else if (!start_st || !lock_flag_ff || latch_ff || passive_s || por_act) begin
      lock_cnt_ff <= 32'h0000_0000;
    end else if (!latch_set) begin
      lock_cnt_ff <= lock_cnt_ff + 32'h0000_0001;
    end
  end

  assign latch_set = start_st && lock_flag_ff && !latch_ff && !passive_s && !por_act
                     && (lock_cnt_ff >= lock_tmo_ff - 32'h0000_0001);

  // stop hold, or brake hold after a clock-loss trip
  assign hold_cond = stop_ff || (brake_ff && latch_clk_ff);
  assign hold_done = hold_cond && (hold_cnt_ff >= STOP_CLEAR_CYC - 1);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_cnt_ff <= 32'h0000_0000;
    end else if (!hold_cond) begin
      hold_cnt_ff <= 32'h0000_0000;
    end else if (!hold_done) begin
      hold_cnt_ff <= hold_cnt_ff + 32'h0000_0001;
    end
  end

  // the latch: a new trip wins over a clear in the same cycle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      latch_ff <= 1'b0;
      latch_clk_ff <= 1'b0;
    end else if (latch_set) begin
      latch_ff <= 1'b1;
      latch_clk_ff <= clk_lost;
    end else if (hold_done || por_act) begin
      latch_ff <= 1'b0;
      latch_clk_ff <= 1'b0;
    end
  end

  // ***************************************************************
  // output gating
  // ***************************************************************
  logic [2:0] nxt_high;
  logic [2:0] nxt_low;
  logic nxt_duty_full;
  logic nxt_limit_en;
  logic braking;
  logic [2:0] high_ff;
  logic [2:0] low_ff;
  logic duty_full_ff;
  logic limit_en_ff;
  logic power_save_ff;
  logic speed_en_ff;

  // brake acts inside the start state
  assign braking = start_st && brake_ff;

  // priority chain for the gate enables
  always_comb begin
    nxt_high = 3'h0;
    nxt_low = 3'h0;
    nxt_duty_full = 1'b0;
    nxt_limit_en = 1'b1;
    if (por_act || !start_st) begin
      // everything off in reset and stop
      nxt_high = 3'h0;
    end else if (uv_ff || latch_ff) begin
      // high side off, low side follows commutation
      nxt_low = comm_low_i;
    end else if (clk_lost) begin
      // pwm side off; drops back once the clock returns
      nxt_low = comm_low_i;
    end else if (braking) begin
      // short the windings through the high side
      nxt_high = 3'h7;
      nxt_duty_full = 1'b1;
      nxt_limit_en = 1'b0;
    end else if (state_ff == mbp_pkg::MBP_RUNNING) begin
      // normal drive, limiter cuts the pwm side
      nxt_high = (pwm_on_i && !over_current_i) ? comm_high_i : 3'h0;
      nxt_low = comm_low_i;
    end
  end

  // every output comes from a flop
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      high_ff <= 3'h0;
      low_ff <= 3'h0;
      duty_full_ff <= 1'b0;
      limit_en_ff <= 1'b1;
      power_save_ff <= 1'b1;
      speed_en_ff <= 1'b0;
    end else begin
      high_ff <= nxt_high;
      low_ff <= nxt_low;
      duty_full_ff <= nxt_duty_full;
      limit_en_ff <= nxt_limit_en;
      // power saving while stopped, speed loop waits for settling
      power_save_ff <= !start_st;
      speed_en_ff <= (state_ff == mbp_pkg::MBP_RUNNING) && start_st && !por_act && !braking;
    end
  end

  assign phase_a_high_drive_o = high_ff[0];
  assign phase_b_high_drive_o = high_ff[1];
  assign phase_c_high_drive_o = high_ff[2];
  assign low_drive_o = low_ff;
  assign speed_lock_flag_out_o = lock_flag_ff;
  assign duty_full_o = duty_full_ff;
  assign current_limit_en_o = limit_en_ff;
  assign power_save_o = power_save_ff;
  assign speed_ctrl_en_o = speed_en_ff;

  // ***************************************************************
  // apb read side
  // ***************************************************************
  logic [31:0] nxt_rdata;
  logic nxt_err;
  logic [31:0] rdata_ff;
  logic err_ff;
  logic rdy_ff;

  // read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    unique case (paddr_i)
      mbp_pkg::CTRL_OFS: begin
        nxt_rdata[mbp_pkg::CTRL_STOP_BIT] = stop_ff;
        nxt_rdata[mbp_pkg::CTRL_BRAKE_BIT] = brake_ff;
      end
      mbp_pkg::STATUS_OFS: begin
        nxt_rdata[mbp_pkg::ST_POR_BIT] = por_act;
        nxt_rdata[mbp_pkg::ST_UV_BIT] = uv_ff;
        nxt_rdata[mbp_pkg::ST_LATCH_BIT] = latch_ff;
        nxt_rdata[mbp_pkg::ST_CLK_LOST_BIT] = clk_lost;
        nxt_rdata[mbp_pkg::ST_SETTLING_BIT] = (state_ff == mbp_pkg::MBP_SETTLING);
        nxt_rdata[mbp_pkg::ST_LOCK_FLAG_BIT] = lock_flag_ff;
        nxt_rdata[mbp_pkg::ST_PASSIVE_BIT] = passive_s;
        nxt_rdata[mbp_pkg::ST_LATCH_CLK_BIT] = latch_clk_ff;
      end
      mbp_pkg::LOCK_TMO_OFS: nxt_rdata = lock_tmo_ff;
      mbp_pkg::CLK_WD_OFS: nxt_rdata[15:0] = clk_wd_ff;
      default: nxt_err = 1'b1;
    endcase
  end

  // answer in the cycle after setup, so each access lasts two cycles
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h0000_0000;
      err_ff <= 1'b0;
      rdy_ff <= 1'b0;
    end else begin
      rdy_ff <= psel_i && !penable_i;
      err_ff <= psel_i && !penable_i && nxt_err;
      rdata_ff <= (psel_i && !penable_i && !pwrite_i) ? nxt_rdata : 32'h0000_0000;
    end
  end

  assign prdata_o = rdata_ff;
  assign pready_o = rdy_ff;
  assign pslverr_o = err_ff;

endmodule // mbp_ctrl

/* File: include/mbp_pkg.sv */
/*
 * constants shared by the brake and protection supervisor: register map,
 * field positions, reset values and cycle counts.
 * assumes a 25 MHz core clock; long counts are defaults of top parameters.
 */
package mbp_pkg;

  // ***************************************************************
  // clock and times
  // ***************************************************************
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint STOP_CLEAR_NS = 1000000; // least stop or brake hold that clears
  localparam longint STOP_CLEAR_CYC = (STOP_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint LOCK_SEC_PER_UF = 37;    // 6.3 V supply; 30 at 5.0 V
  localparam longint LOCK_CAP_NF = 100;       // timing capacitance
  localparam longint LOCK_TIMEOUT_MS = LOCK_SEC_PER_UF * LOCK_CAP_NF;
  localparam longint LOCK_TIMEOUT_CYC = LOCK_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint SETTLE_US = 1000;        // oscillator settle wait after start
  localparam longint SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ***************************************************************
  // register map
  // ***************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LOCK_TMO_OFS = 8'h08;
  localparam logic [7:0] CLK_WD_OFS = 8'h0C;

  // ctrl fields
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_BRAKE_BIT = 1;
  localparam logic CTRL_STOP_RST = 1'b1;
  localparam logic CTRL_BRAKE_RST = 1'b0;

  // status fields
  localparam int ST_POR_BIT = 0;
  localparam int ST_UV_BIT = 1;
  localparam int ST_LATCH_BIT = 2;
  localparam int ST_CLK_LOST_BIT = 3;
  localparam int ST_SETTLING_BIT = 4;
  localparam int ST_LOCK_FLAG_BIT = 5;
  localparam int ST_PASSIVE_BIT = 6;
  localparam int ST_LATCH_CLK_BIT = 7;

  // clock watchdog limit after reset, in core cycles
  localparam logic [15:0] CLK_WD_RST = 16'h0100;

  // run state of the supervisor
  typedef enum logic [1:0] {
    MBP_STOPPED,
    MBP_SETTLING,
    MBP_RUNNING
  } mbp_state_t;

endpackage

/* File: include/mbp_wd_if.sv */
/*
 * carrier between the supervisor and its reference clock watchdog.
 * assumes both ends run on the core clock.
 */
interface mbp_wd_if;
  logic ref_edge;
  logic enable;
  logic [15:0] limit;
  logic lost;

  modport ctrl (output ref_edge, output enable, output limit, input lost);
  modport wd (input ref_edge, input enable, input limit, output lost);
endinterface

/* File: verification/mbp_ctrl_sva.sv */
/*
 * port checker for the brake and protection supervisor.
 * assumes pins reach the outputs through two sync flops and one register.
 */
module mbp_ctrl_sva #(
  parameter int unsigned STOP_CLEAR_CYC = 20,
  parameter int unsigned LOCK_TIMEOUT_CYC = 50,
  parameter int unsigned SETTLE_CYC = 10
) (
  // clock, reset and bus
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins
  input wire logic protect_timer_reset_pin_i,
  input wire logic vcc_below_low_i,
  input wire logic speed_in_window_i,
  // outputs
  input wire logic phase_a_high_drive_o,
  input wire logic phase_b_high_drive_o,
  input wire logic phase_c_high_drive_o,
  input wire logic [2:0] low_drive_o,
  input wire logic speed_lock_flag_out_o,
  input wire logic duty_full_o,
  input wire logic current_limit_en_o,
  input wire logic power_save_o,
  input wire logic speed_ctrl_en_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  logic [2:0] hi;
  assign hi = {phase_c_high_drive_o, phase_b_high_drive_o, phase_a_high_drive_o};

  // ***************************************************************
  // assertions
  // ***************************************************************
  // four cycles cover two sync flops plus the output register
  sequence por_held; !protect_timer_reset_pin_i [*4]; endsequence
  sequence uv_held; vcc_below_low_i [*5]; endsequence // one more for the trip flop
  // settling is assumed to last at least eight cycles
  sequence start_edge; $fell(power_save_o); endsequence

  por_drive_off_a: assert property (por_held |-> hi == 3'h0 && low_drive_o == 3'h0)
    else $error("drive on during power-on reset");
  uv_high_off_a: assert property (uv_held |-> hi == 3'h0)
    else $error("high side on in undervoltage");
  brake_limit_off_a: assert property (duty_full_o |-> !current_limit_en_o)
    else $error("limiter active while braking");
  brake_full_duty_a: assert property (duty_full_o |-> !speed_ctrl_en_o)
    else $error("speed control on while braking");
  brake_short_a: assert property (duty_full_o |-> hi == 3'h7 && low_drive_o == 3'h0)
    else $error("brake pattern wrong");
  stop_save_a: assert property (power_save_o |-> hi == 3'h0 && !speed_ctrl_en_o)
    else $error("drive on in stop state");
  settle_wait_a: assert property (start_edge |-> !speed_ctrl_en_o [*8])
    else $error("speed control before settling");
  lock_in_a: assert property (speed_in_window_i [*5] |-> !speed_lock_flag_out_o)
    else $error("lock flag high inside window");
  lock_out_a: assert property (!speed_in_window_i [*4] |-> speed_lock_flag_out_o)
    else $error("lock flag low outside window");
  bus_answer_a: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no bus answer after setup");
  bus_error_a: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule // mbp_ctrl_sva

bind mbp_ctrl mbp_ctrl_sva #(.STOP_CLEAR_CYC(STOP_CLEAR_CYC),
  .LOCK_TIMEOUT_CYC(LOCK_TIMEOUT_CYC), .SETTLE_CYC(SETTLE_CYC)) u_mbp_ctrl_sva (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o),
  .protect_timer_reset_pin_i(protect_timer_reset_pin_i), .vcc_below_low_i(vcc_below_low_i),
  .speed_in_window_i(speed_in_window_i), .phase_a_high_drive_o(phase_a_high_drive_o),
  .phase_b_high_drive_o(phase_b_high_drive_o), .phase_c_high_drive_o(phase_c_high_drive_o),
  .low_drive_o(low_drive_o), .speed_lock_flag_out_o(speed_lock_flag_out_o),
  .duty_full_o(duty_full_o), .current_limit_en_o(current_limit_en_o),
  .power_save_o(power_save_o), .speed_ctrl_en_o(speed_ctrl_en_o));

/* File: verification/mbp_power_stage.sv */
/*
 * model of the external power transistors and motor phase nodes.
 * assumes one active-high gate enable per transistor from the supervisor.
 */
module mbp_power_stage (
  // clock
  input wire logic core_clk_i,
  // gate enables
  input wire logic [2:0] high_en_i,
  input wire logic [2:0] low_en_i,
  // phase nodes and fault flag
  output logic [2:0] phase_v_o,
  output logic shoot_o
);
  logic [2:0] float_ff = 3'h5;

  // an undriven node floats: toggle it so a stale level never passes for drive
  always_ff @(posedge core_clk_i) begin
    float_ff <= ~float_ff;
  end

  // all high sides on short the windings
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      phase_v_o[i] = high_en_i[i] ? 1'b1 : (low_en_i[i] ? 1'b0 : float_ff[i]);
    end
  end

  // both transistors of one leg on short the supply
  assign shoot_o = |(high_en_i & low_en_i);
endmodule // mbp_power_stage

/* File: verification/motor_brake_protection_ctrl_bench.sv */
/*
 * self-checking bench for the brake and protection supervisor.
 * assumes the short count parameters below and a 25 MHz core clock.
 */
module motor_brake_protection_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned STOP_CLR = 20;
  localparam int unsigned LOCK_TMO = 50;
  localparam int unsigned SETTLE = 10;
  localparam logic [9:0] M_RUN = 10'h3F8;
  localparam logic [9:0] M_OFF = 10'h03F;
  logic core_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic ref_clk = 1'b0, ref_run = 1'b1, in_win = 1'b1, por_pin = 1'b1, passive = 1'b0;
  logic vlow = 1'b0, vhigh = 1'b1, pwm = 1'b1, oc = 1'b0, chk_stb = 1'b0, shoot;
  logic [2:0] c_hi = 3'h1, c_lo = 3'h2, hi, lo, ph_v;
  logic lock_flag, duty_full, lim_en, psave, spd_en;
  logic [9:0] dv;
  logic [33:0] q_bus[$], b;
  logic [19:0] q_drv[$], d;
  int n_errors = 0, samples_checked = 0, ref_cnt = 0;

  assign dv = {psave, spd_en, lim_en, duty_full, hi, lo};
  always #20 core_clk_i = ~core_clk_i;

  mbp_ctrl #(.STOP_CLEAR_CYC(STOP_CLR), .LOCK_TIMEOUT_CYC(LOCK_TMO), .SETTLE_CYC(SETTLE))
  u_mbp_ctrl (.core_clk_i(core_clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .ref_clk_pin_i(ref_clk),
    .speed_in_window_i(in_win), .protect_timer_reset_pin_i(por_pin),
    .timer_pin_passive_i(passive), .vcc_below_low_i(vlow), .vcc_above_high_i(vhigh),
    .comm_high_i(c_hi), .comm_low_i(c_lo), .pwm_on_i(pwm), .over_current_i(oc),
    .phase_a_high_drive_o(hi[0]), .phase_b_high_drive_o(hi[1]),
    .phase_c_high_drive_o(hi[2]), .low_drive_o(lo), .speed_lock_flag_out_o(lock_flag),
    .duty_full_o(duty_full), .current_limit_en_o(lim_en), .power_save_o(psave),
    .speed_ctrl_en_o(spd_en));

  mbp_power_stage u_mbp_power_stage (.core_clk_i(core_clk_i), .high_en_i(hi),
    .low_en_i(lo), .phase_v_o(ph_v), .shoot_o(shoot));

  // ***************************************************************
  // stimulus helpers
  // ***************************************************************
  // reference clock toggles every four core cycles while running
  always @(posedge core_clk_i) begin
    ref_cnt <= ref_cnt + 1;
    if (ref_run && ref_cnt % 4 == 0) ref_clk <= ~ref_clk;
  end

  task automatic err(input string s);
    n_errors++;
    $display("MISMATCH at %0t: %s", $time, s);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // one apb transfer; the answer is noted for the monitor
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     input logic [32:0] ex);
    @(posedge core_clk_i);
    q_bus.push_back({~wr, ex});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_ctrl(input logic [31:0] v);
    apb(1'b1, mbp_pkg::CTRL_OFS, v, 33'h0);
  endtask

  task automatic chk(input logic [9:0] ex, input logic [9:0] m);
    @(posedge core_clk_i);
    q_drv.push_back({m, ex});
    chk_stb <= 1'b1;
    @(posedge core_clk_i);
    chk_stb <= 1'b0;
  endtask

  // commutation never drives both transistors of one leg
  task automatic new_pattern();
    logic [5:0] r;
    r = 6'($urandom);
    c_hi <= r[2:0];
    c_lo <= r[5:3] & ~r[2:0];
    cyc(2);
  endtask

  function automatic logic [9:0] exp_run();
    return {4'b0110, c_hi, 3'h0};
  endfunction

  function automatic logic [9:0] exp_off();
    return {7'h0, c_lo};
  endfunction

  // ***************************************************************
  // monitor: compares every answer with the oldest note
  // ***************************************************************
  always @(posedge core_clk_i) begin
    if (shoot === 1'b1) err("leg short");
    if (duty_full === 1'b1 && ph_v !== 3'h7) err("windings not shorted");
    if (pready === 1'b1) begin
      if (q_bus.size() == 0) err("unexpected bus answer");
      else begin
        b = q_bus.pop_front();
        samples_checked++;
        if (pslverr !== b[32] || (b[33] && prdata !== b[31:0])) err("bus answer");
      end
    end
    if (chk_stb === 1'b1) begin
      d = q_drv.pop_front();
      samples_checked++;
      if ((dv & d[19:10]) !== d[9:0]) err("gate outputs");
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // runaway guard, well beyond the several hundred cycles the tests need
  initial begin
    #(40 * 20000);
    err("watchdog expired");
    stop_test();
  end

  // ***************************************************************
  // tests
  // ***************************************************************
  initial begin
    void'($urandom(50243));
    cyc(3);
    reset_i <= 1'b0;
    apb(1'b0, mbp_pkg::CTRL_OFS, 32'h0, 33'h1);
    apb(1'b0, mbp_pkg::LOCK_TMO_OFS, 32'h0, {1'b0, 32'(LOCK_TMO)});
    apb(1'b0, mbp_pkg::CLK_WD_OFS, 32'h0, 33'h100);
    apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
    apb(1'b1, mbp_pkg::CLK_WD_OFS, 32'h20, 33'h0);
    apb(1'b1, mbp_pkg::STATUS_OFS, 32'hFF, 33'h0);
    chk(10'h200, 10'h37F);
    $display("test registers done");
    new_pattern();
    oc <= 1'b1;
    wr_ctrl(32'h2);
    chk(10'h078, 10'h3FF);
    cyc(SETTLE + 10);
    chk(10'h078, 10'h3FF);
    oc <= 1'b0;
    wr_ctrl(32'h0);
    cyc(3);
    chk(exp_run(), M_RUN);
    $display("test brake done");
    wr_ctrl(32'h1);
    cyc(3);
    chk(10'h200, 10'h37F);
    wr_ctrl(32'h0);
    chk(10'h000, 10'h37F);
    cyc(SETTLE);
    chk(exp_run(), M_RUN);
    $display("test settle done");
    new_pattern();
    ref_run <= 1'b0;
    cyc(60);
    chk(exp_off(), M_OFF);
    ref_run <= 1'b1;
    cyc(8);
    chk(exp_run(), M_RUN);
    $display("test clock loss done");
    in_win <= 1'b0;
    cyc(LOCK_TMO + 10);
    chk(exp_off(), M_OFF);
    in_win <= 1'b1;
    cyc(10);
    chk(exp_off(), M_OFF);
    wr_ctrl(32'h1);
    cyc(5);
    wr_ctrl(32'h0);
    cyc(SETTLE + 5);
    chk(exp_off(), M_OFF);
    wr_ctrl(32'h1);
    cyc(STOP_CLR + 5);
    wr_ctrl(32'h0);
    cyc(SETTLE + 5);
    chk(exp_run(), M_RUN);
    $display("test lock latch done");
    in_win <= 1'b0;
    ref_run <= 1'b0;
    cyc(LOCK_TMO + 40);
    ref_run <= 1'b1;
    in_win <= 1'b1;
    cyc(10);
    chk(exp_off(), M_OFF);
    wr_ctrl(32'h2);
    cyc(STOP_CLR + 5);
    wr_ctrl(32'h0);
    cyc(5);
    chk(exp_run(), M_RUN);
    $display("test latch in clock loss done");
    wr_ctrl(32'h2);
    vlow <= 1'b1;
    vhigh <= 1'b0;
    cyc(6);
    chk(exp_off() & 10'h038, M_RUN & 10'h038);
    wr_ctrl(32'h0);
    cyc(4);
    chk(exp_off(), M_OFF);
    vlow <= 1'b0;
    cyc(6);
    chk(exp_off(), M_OFF);
    vhigh <= 1'b1;
    cyc(6);
    chk(exp_run(), M_RUN);
    $display("test undervoltage done");
    passive <= 1'b1;
    in_win <= 1'b0;
    ref_run <= 1'b0;
    cyc(LOCK_TMO + 40);
    chk(exp_run(), M_RUN);
    ref_run <= 1'b1;
    in_win <= 1'b1;
    cyc(5);
    passive <= 1'b0;
    $display("test passive done");
    por_pin <= 1'b0;
    cyc(6);
    chk(10'h000, M_OFF);
    por_pin <= 1'b1;
    cyc(5);
    $display("test power-on reset done");
    stop_test();
  end
endmodule // motor_brake_protection_ctrl_bench
